// ### design/eas_pkg.sv
package eas_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] EAS_ADDR_ACCUMULATION_MODE_CONFIG   = 8'h00;
    localparam logic [7:0] EAS_ADDR_STATUS    = 8'h04;
    localparam logic [7:0] EAS_ADDR_MASK      = 8'h08;
    localparam logic [7:0] EAS_ADDR_VRMS_B    = 8'h0c;
    localparam logic [7:0] EAS_ADDR_TERMS     = 8'h10;
    localparam logic [7:0] EAS_ADDR_WARN      = 8'h14;

    // ************************************************************
    // field layout of accumulation_mode_config
    // ************************************************************
    localparam int EAS_WATT_LSB   = 0;
    localparam int EAS_VAR_LSB    = 2;
    localparam int EAS_TOPO_LSB   = 4;
    localparam int EAS_DIP_BIT    = 6;
    localparam int EAS_RSVD_BIT   = 7;
    localparam logic [7:0] EAS_ACCUMULATION_MODE_CONFIG_RESET = 8'h80;
    localparam logic [7:0] EAS_ACCUMULATION_MODE_CONFIG_WMASK = 8'h7f;

    // status bits
    localparam int EAS_ST_DIP     = 0;
    localparam int EAS_ST_TERMERR = 1;
    localparam int EAS_ST_W       = 2;
    localparam logic [EAS_ST_W-1:0] EAS_MASK_RESET = 2'h0;
    // freq_out_*_terms, three 3-bit fields, phase b is bit 1 of each
    localparam int EAS_TERM_W     = 9;
    localparam logic [EAS_TERM_W-1:0] EAS_TERMS_RESET = 9'h1ff;

    // ************************************************************
    // modes
    // ************************************************************
    typedef enum logic [1:0] {
        EAS_VAR_SIGNED = 2'b00, EAS_VAR_RSVD = 2'b01, EAS_VAR_BY_P = 2'b10, EAS_VAR_ABS = 2'b11
    } eas_var_e;
    typedef enum logic [1:0] {
        EAS_TOPO_4W = 2'b00, EAS_TOPO_3W = 2'b01, EAS_TOPO_RSVD = 2'b10, EAS_TOPO_4WD = 2'b11
    } eas_topo_e;
endpackage

// ### design/eas_dp_if.sv
`timescale 1ns/10ps
// datapath configuration carried from the register file to the selector
interface eas_dp_if;
    import eas_pkg::*;
    eas_var_e   var_mode;
    eas_topo_e  topo;
    modport ctl (output var_mode, output topo);
    modport dp  (input  var_mode, input  topo);
endinterface

// ### design/eas_sel.sv
`timescale 1ns/10ps
// ************************************************************
// per-phase product operand and reactive sign selection
// ************************************************************
module eas_sel #(
    parameter int W = 24
) (
    eas_dp_if.dp                 cfg,
    input  wire logic [3*W-1:0]  v_in,
    input  wire logic [3*W-1:0]  i_in,
    input  wire logic [3*W-1:0]  iq_in,
    input  wire logic [3*W-1:0]  p_act,
    input  wire logic [3*W-1:0]  q_raw,
    output logic      [3*W-1:0]  v_sel,
    output logic      [3*W-1:0]  i_sel,
    output logic      [3*W-1:0]  iq_sel,
    output logic      [3*W-1:0]  q_acc
);
    import eas_pkg::*;

    logic signed [W-1:0] va;
    logic signed [W-1:0] vc;

    assign va = v_in[0 +: W];
    assign vc = v_in[2*W +: W];

    // phase b voltage and current follow the wiring topology
    always_comb begin
        v_sel  = v_in;
        i_sel  = i_in;
        iq_sel = iq_in;
        case (cfg.topo)
            EAS_TOPO_3W: begin
                v_sel[W +: W]  = W'(va - vc);
                i_sel[W +: W]  = '0;
                iq_sel[W +: W] = '0;
            end
            EAS_TOPO_4WD: begin
                v_sel[W +: W] = W'(-va);
            end
            default: begin
                v_sel = v_in;
            end
        endcase
    end

    // reactive term per phase, products use the -90 degree current
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ph
            logic signed [W-1:0] q;
            logic signed [W-1:0] p;
            assign q = q_raw[g*W +: W];
            assign p = p_act[g*W +: W];
            // one continuous driver per slice keeps q_acc single-sourced
            assign q_acc[g*W +: W] = (cfg.var_mode == EAS_VAR_BY_P) ? (p[W-1] ? W'(-q) : q) :
                                     (cfg.var_mode == EAS_VAR_ABS)  ? (q[W-1] ? W'(-q) : q) :
                                     q;
        end
    endgenerate
endmodule // eas_sel

// ### design/eas_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - bits 3:2 pick reactive summing mode
// - mode 10: reactive sign follows active sign
// - mode 11: reactive magnitude accumulated
// - reactive products use quarter-period delayed current
// - topology 00: each phase uses own signals
// - topology 01: phase b voltage is a minus c
// - topology 11: phase b voltage is minus a
// - three-wire: line a-c rms in phase b
// - three-wire: phase b current forced to zero
// - style 0: flag while any voltage below level
// - style 1: flag after dip then recovery
// - bit 7 reserved, resets to one
module eas_top #(
    parameter int W = 24
) (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    clk_en,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [7:0]              haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // datapath
    input  wire logic [3*W-1:0]          v_in,
    input  wire logic [3*W-1:0]          i_in,
    input  wire logic [3*W-1:0]          iq_in,
    input  wire logic [3*W-1:0]          p_act,
    input  wire logic [3*W-1:0]          q_raw,
    input  wire logic [3*W-1:0]          v_rms,
    input  wire logic [W-1:0]            vac_rms,
    input  wire logic [W-1:0]            dip_level_threshold,
    output logic      [3*W-1:0]          v_sel,
    output logic      [3*W-1:0]          i_sel,
    output logic      [3*W-1:0]          iq_sel,
    output logic      [3*W-1:0]          q_acc,
    output logic      [1:0]              watt_mode,
    output logic      [W-1:0]            phase_b_voltage_rms,
    output logic      [eas_pkg::EAS_TERM_W-1:0] freq_out_terms,
    output logic                         irq
);
    import eas_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic                   ph_wr;
        logic                   ph_rd;
        logic [7:0]             ph_addr;
        logic [7:0]             accumulation_mode_config;
        logic [EAS_ST_W-1:0]    status;
        logic [EAS_ST_W-1:0]    mask;
        logic [EAS_TERM_W-1:0]  terms;
        logic [2:0]             below;
        logic [2:0]             dipped;
        logic [31:0]            rdata;
        logic [W-1:0]           vrms_b;
    } eas_state_s;

    eas_state_s s_q;
    eas_state_s s_d;

    eas_dp_if dp_cfg();

    logic             dip_event;
    logic [2:0]       below_now;
    logic             term_warn;
    logic             take;
    logic [31:0]      rd_mux;
    logic [EAS_ST_W-1:0] rd_clr;

    assign dp_cfg.var_mode = eas_var_e'(s_q.accumulation_mode_config[EAS_VAR_LSB +: 2]);
    assign dp_cfg.topo     = eas_topo_e'(s_q.accumulation_mode_config[EAS_TOPO_LSB +: 2]);

    eas_sel #(
        .W (W)
    ) u_sel (
        .cfg    (dp_cfg.dp),
        .v_in   (v_in),
        .i_in   (i_in),
        .iq_in  (iq_in),
        .p_act  (p_act),
        .q_raw  (q_raw),
        .v_sel  (v_sel),
        .i_sel  (i_sel),
        .iq_sel (iq_sel),
        .q_acc  (q_acc)
    );

    // ************************************************************
    // dip detection, per phase compare against threshold
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_dip
            assign below_now[g] = v_rms[g*W +: W] < dip_level_threshold;
        end
    endgenerate

    // style 1 fires on the rising side of a dip, style 0 on level
    always_comb begin
        if (s_q.accumulation_mode_config[EAS_DIP_BIT]) begin
            dip_event = |(s_q.dipped & ~below_now);
        end else begin
            dip_event = |below_now;
        end
    end

    // phase b still feeding a converter in three-wire mode is flagged
    assign term_warn = (dp_cfg.topo == EAS_TOPO_3W) &&
                       (s_q.terms[1] | s_q.terms[4] | s_q.terms[7]);

    assign take = hsel && hready && htrans[1];

    // read mux, unused bits read zero, reserved bit 7 of the mode register reads back one
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_clr = '0;
        if (s_q.ph_addr == EAS_ADDR_ACCUMULATION_MODE_CONFIG) begin
            rd_mux[7:0] = s_q.accumulation_mode_config;
        end else if (s_q.ph_addr == EAS_ADDR_STATUS) begin
            rd_mux[EAS_ST_W-1:0] = s_q.status;
            rd_clr = s_q.status;
        end else if (s_q.ph_addr == EAS_ADDR_MASK) begin
            rd_mux[EAS_ST_W-1:0] = s_q.mask;
        end else if (s_q.ph_addr == EAS_ADDR_VRMS_B) begin
            rd_mux[W-1:0] = s_q.vrms_b;
        end else if (s_q.ph_addr == EAS_ADDR_TERMS) begin
            rd_mux[EAS_TERM_W-1:0] = s_q.terms;
        end else if (s_q.ph_addr == EAS_ADDR_WARN) begin
            rd_mux[0] = term_warn;
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.ph_wr = take && hwrite;
        s_d.ph_rd = take && !hwrite;
        if (take) begin
            s_d.ph_addr = haddr;
        end
        // write data arrives one cycle after its address
        if (s_q.ph_wr) begin
            if (s_q.ph_addr == EAS_ADDR_ACCUMULATION_MODE_CONFIG) begin
                s_d.accumulation_mode_config = (hwdata[7:0] & EAS_ACCUMULATION_MODE_CONFIG_WMASK) | (s_q.accumulation_mode_config & ~EAS_ACCUMULATION_MODE_CONFIG_WMASK);
            end else if (s_q.ph_addr == EAS_ADDR_MASK) begin
                s_d.mask = hwdata[EAS_ST_W-1:0];
            end else if (s_q.ph_addr == EAS_ADDR_TERMS) begin
                s_d.terms = hwdata[EAS_TERM_W-1:0];
            end
        end
        // read address latched at address phase; rdata is held at zero, hrdata comes from rd_mux in data phase
        if (take && !hwrite) begin
            s_d.ph_addr = haddr;
        end
        if (s_q.ph_rd) begin
            s_d.status = s_q.status & ~rd_clr;
        end
        s_d.rdata = 32'h0000_0000;
        s_d.below = below_now;
        s_d.dipped = (s_q.dipped | below_now) & ~(s_q.dipped & ~below_now);
        // set wins over read clear
        if (dip_event) begin
            s_d.status[EAS_ST_DIP] = 1'b1;
        end
        if (term_warn) begin
            s_d.status[EAS_ST_TERMERR] = 1'b1;
        end
        // phase b rms carries the a-c line voltage in three-wire mode
        if (dp_cfg.topo == EAS_TOPO_3W) begin
            s_d.vrms_b = vac_rms;
        end else begin
            s_d.vrms_b = v_rms[W +: W];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q         <= '0;
            s_q.accumulation_mode_config <= EAS_ACCUMULATION_MODE_CONFIG_RESET;
            s_q.mask    <= EAS_MASK_RESET;
            s_q.terms   <= EAS_TERMS_RESET;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // read data is combinational off flops; a zero-wait slave keeps hready simple
    assign hrdata              = s_q.ph_rd ? rd_mux : 32'h0000_0000;
    assign hreadyout           = 1'b1;
    assign hresp               = 1'b0;
    assign watt_mode           = s_q.accumulation_mode_config[EAS_WATT_LSB +: 2];
    assign phase_b_voltage_rms = s_q.vrms_b;
    assign freq_out_terms      = s_q.terms;
    assign irq                 = |(s_q.status & s_q.mask);
endmodule // eas_top

// ### bench/eas_top_properties.sv
`timescale 1ns/10ps
// ************************************************************
// port-level checker of the mode selection
// ************************************************************
module eas_top_properties #(parameter int W = 24) (
    input wire logic            hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp, irq,
    input wire logic [7:0]      haddr,
    input wire logic [1:0]      htrans, watt_mode,
    input wire logic [31:0]     hwdata, hrdata,
    input wire logic [3*W-1:0]  v_in, i_in, iq_in, p_act, q_raw, v_rms, v_sel, i_sel, iq_sel, q_acc,
    input wire logic [W-1:0]    vac_rms, phase_b_voltage_rms
);
    import eas_pkg::*;
    logic [7:0] mode_q;
    logic       wr_q;
    logic       rd_q;
    // shadow of the mode register, rebuilt from bus traffic so outputs can be judged
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= EAS_ACCUMULATION_MODE_CONFIG_RESET;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else if (clk_en) begin
            wr_q <= hsel && hready && htrans[1] && hwrite && haddr == EAS_ADDR_ACCUMULATION_MODE_CONFIG;
            rd_q <= hsel && hready && htrans[1] && !hwrite;
            if (wr_q) mode_q <= (hwdata[7:0] & EAS_ACCUMULATION_MODE_CONFIG_WMASK) | EAS_ACCUMULATION_MODE_CONFIG_RESET;
        end
    end
    wire [1:0]          tp = mode_q[5:4];
    wire [1:0]          vm = mode_q[3:2];
    wire signed [W-1:0] va = v_in[W-1:0];
    wire signed [W-1:0] vc = v_in[3*W-1:2*W];
    wire signed [W-1:0] qa = q_raw[W-1:0];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled or errored");
    a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0) else $error("read data outside read");
    a_watt_copy: assert property (watt_mode == mode_q[1:0]) else $error("active mode not reg copy");
    a_topo_own: assert property (!tp[0] |-> v_sel == v_in && i_sel == i_in)
        else $error("own phase operands wrong");
    a_topo_delta: assert property (tp == 2'b01 |-> v_sel[2*W-1:W] == va - vc && i_sel[2*W-1:W] == '0)
        else $error("three wire operands wrong");
    a_topo_neg: assert property (tp == 2'b11 |-> v_sel[2*W-1:W] == -va) else $error("delta b voltage wrong");
    a_quad_curr: assert property (iq_sel[W-1:0] == iq_in[W-1:0]) else $error("quadrature current wrong");
    a_var_sign: assert property (vm == 2'b10 |-> q_acc[W-1:0] == (p_act[W-1] ? -qa : qa))
        else $error("reactive sign mode wrong");
    a_var_abs: assert property (vm == 2'b11 |-> q_acc[W-1:0] == (qa[W-1] ? -qa : qa))
        else $error("reactive magnitude wrong");
    a_rms_lag: assert property ($past(hresetn) && $past(clk_en) |->
        phase_b_voltage_rms == $past(tp == 2'b01 ? vac_rms : v_rms[2*W-1:W])) else $error("b rms wrong");
    c_delta: cover property (tp == 2'b01);
    c_abs: cover property (vm == 2'b11 && qa[W-1]);
    c_irq: cover property ($rose(irq));
endmodule // eas_top_properties

// ### bench/tb_energy_accumulation_select.sv
`timescale 1ns/10ps
module tb_energy_accumulation_select;
    import eas_pkg::*;
    localparam int W = 24;
    logic hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0;
    logic [7:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 0, rd;
    logic [3*W-1:0] v_in = 0, i_in = 0, iq_in = 0, p_act = 0, q_raw = 0, v_rms = 0;
    logic [W-1:0] vac_rms = 0, dip_level_threshold = 0;
    wire [3*W-1:0] v_sel, i_sel, iq_sel, q_acc;
    wire [W-1:0] phase_b_voltage_rms;
    wire [8:0] freq_out_terms;
    wire [31:0] hrdata;
    wire [1:0] watt_mode;
    wire hready, hreadyout, hresp, irq;
    int error_cnt = 0, n_checks = 0;
    assign hready = hreadyout; // single slave drives the bus ready
    eas_top #(.W(W)) dut (.*);
    initial forever #20 hclk = ~hclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single transfer; hwdata only in the data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [31:0] exp_vb(input logic [1:0] tp, input logic [3*W-1:0] v);
        case (tp)
            2'b01: return 32'(W'(v[W-1:0] - v[3*W-1:2*W]));
            2'b11: return 32'(W'(-v[W-1:0]));
            default: return 32'(v[2*W-1:W]); // reserved code acts as own-phase
        endcase
    endfunction
    function automatic logic [31:0] exp_q(input logic [1:0] vm, input logic [W-1:0] q, input logic [W-1:0] p);
        if ((vm == 2'b11 && q[W-1]) || (vm == 2'b10 && p[W-1])) return 32'(W'(-q));
        return 32'(q);
    endfunction
    initial begin
        #400000;
        error_cnt++;
        tally_and_finish;
    end
    initial begin
        logic [31:0] m;
        void'($urandom(32'h463a4599));
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        bus(0, EAS_ADDR_ACCUMULATION_MODE_CONFIG, 0);
        check(rd, 32'h80);
        bus(0, EAS_ADDR_TERMS, 0);
        check(rd, 32'h1ff);
        bus(0, 8'h18, 0);
        check(rd, 32'h0);
        bus(1, EAS_ADDR_TERMS, 0);
        // the register updates at the data-phase edge, so look once it has settled
        @(negedge hclk);
        check(32'(freq_out_terms), 32'h0);
        // every topology and reactive mode, random operands
        for (int k = 0; k < 64; k++) begin
            m = 32'((k & 15) << 2) | $urandom_range(3) | ((k & 16) << 3);
            bus(1, EAS_ADDR_ACCUMULATION_MODE_CONFIG, m);
            {v_in, i_in, iq_in} <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
            {p_act, q_raw, v_rms} <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
            vac_rms <= 24'($urandom);
            repeat (2) @(posedge hclk);
            check(32'(v_sel[2*W-1:W]), exp_vb(m[5:4], v_in));
            check(32'(i_sel[2*W-1:W]), m[5:4] == 2'b01 ? 32'h0 : 32'(i_in[2*W-1:W]));
            check(32'(iq_sel[W-1:0]), 32'(iq_in[W-1:0]));
            check(32'(q_acc[W-1:0]), exp_q(m[3:2], q_raw[W-1:0], p_act[W-1:0]));
            check(32'(phase_b_voltage_rms), 32'(m[5:4] == 2'b01 ? vac_rms : v_rms[2*W-1:W]));
            bus(0, EAS_ADDR_ACCUMULATION_MODE_CONFIG, 0);
            check(rd, (m & 32'h7f) | 32'h80);
        end
        // level style: masked, then unmasked, then cleared once recovered
        bus(1, EAS_ADDR_ACCUMULATION_MODE_CONFIG, 0);
        v_rms <= {3{24'h000100}};
        dip_level_threshold <= 24'h000080;
        bus(0, EAS_ADDR_STATUS, 0);
        v_rms[W-1:0] <= 24'h40;
        repeat (3) @(posedge hclk);
        check(32'(irq), 32'h0);
        bus(1, EAS_ADDR_MASK, 1);
        @(posedge hclk);
        check(32'(irq), 32'h1);
        bus(0, EAS_ADDR_STATUS, 0);
        check(rd & 1, 32'h1);
        v_rms[W-1:0] <= 24'h100;
        repeat (3) @(posedge hclk);
        bus(0, EAS_ADDR_STATUS, 0);
        bus(0, EAS_ADDR_STATUS, 0);
        check(rd & 1, 32'h0);
        // recovery style: nothing while low, flag once back above
        bus(1, EAS_ADDR_ACCUMULATION_MODE_CONFIG, 32'h40);
        v_rms[W-1:0] <= 24'h40;
        repeat (3) @(posedge hclk);
        bus(0, EAS_ADDR_STATUS, 0);
        bus(0, EAS_ADDR_STATUS, 0);
        check(rd & 1, 32'h0);
        v_rms[W-1:0] <= 24'h100;
        repeat (3) @(posedge hclk);
        check(32'(irq), 32'h1);
        bus(0, EAS_ADDR_STATUS, 0);
        check(rd & 1, 32'h1);
        // three-wire with phase b still feeding a converter raises the warning
        bus(1, EAS_ADDR_TERMS, 32'h002);
        bus(1, EAS_ADDR_ACCUMULATION_MODE_CONFIG, 32'h10);
        bus(0, EAS_ADDR_WARN, 0);
        check(rd, 32'h1);
        bus(0, EAS_ADDR_STATUS, 0);
        check(rd & 32'h2, 32'h2);
        tally_and_finish;
    end
endmodule // tb_energy_accumulation_select
bind eas_top eas_top_properties #(.W(W)) u_props (.*);
